// ### rtl/tfs_conv_seq.sv
// Conversion pass sequencer over the enabled channels
`timescale 1ns/1ps
module tfs_conv_seq #(
	parameter int CONV_CYCLES_P = tfs_pkg::CONV_CYCLES
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ready_i,
	input  wire logic       standby_i,
	input  wire logic       trigger_i,
	input  wire logic [2:0] chan_en_i,
	output logic            busy_o,
	output logic      [1:0] chan_o
);
	import tfs_pkg::*;

	typedef enum logic {SQ_IDLE, SQ_CONV} tfs_seq_state_t;

	localparam logic [CONV_CNT_W-1:0] CNT_LAST = CONV_CNT_W'(CONV_CYCLES_P - 1);

	tfs_seq_state_t         st_q, st_d;
	logic [1:0]             chan_q, chan_d;
	logic [CONV_CNT_W-1:0]  cnt_q, cnt_d;
	logic                   busy_q;
	logic [2:0]             en_past_q;
	logic [2:0]             first_w, next_w;
	logic                   cnt_done_w, go_w;

	// ==================================================
	// Channel search
	function automatic logic [2:0] tfs_pick(input logic [2:0] en, input logic [1:0] from, input logic first);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 2; i >= 0; i--) begin
			if (en[i] && (first || i > int'(from))) begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction : tfs_pick

	assign first_w    = tfs_pick(chan_en_i, 2'h0, 1'b1);
	assign next_w     = tfs_pick(chan_en_i, chan_q, 1'b0);
	assign cnt_done_w = (cnt_q == CNT_LAST);
	assign go_w       = ready_i && (!standby_i || trigger_i) && first_w[2];

	// ==================================================
	// Pass control
	always_comb begin
		st_d   = st_q;
		chan_d = chan_q;
		cnt_d  = cnt_q;
		unique case (st_q)
			SQ_IDLE: begin
				if (go_w) begin // RL5 RL14
					st_d   = SQ_CONV;
					chan_d = first_w[1:0]; // RL15
					cnt_d  = '0;
				end
			end
			SQ_CONV: begin
				if (!cnt_done_w) begin
					cnt_d = CONV_CNT_W'(cnt_q + 1'b1);
				end else if (next_w[2]) begin
					chan_d = next_w[1:0]; // RL15
					cnt_d  = '0;
				end else if (!standby_i && ready_i && first_w[2]) begin
					chan_d = first_w[1:0]; // RL14
					cnt_d  = '0;
				end else begin
					st_d = SQ_IDLE; // RL16
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_q      <= SQ_IDLE;
			chan_q    <= 2'h0;
			cnt_q     <= '0;
			busy_q    <= 1'b0;
			en_past_q <= 3'h0;
		end else begin
			st_q      <= st_d;
			chan_q    <= chan_d;
			cnt_q     <= cnt_d;
			busy_q    <= (st_d == SQ_CONV);
			en_past_q <= chan_en_i;
		end
	end

	assign busy_o = busy_q;
	assign chan_o = chan_q;

	// ==================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_oneshot_go: assert property ((st_q == SQ_IDLE) && standby_i && trigger_i && ready_i && first_w[2] |=> busy_o) // RL5
		else $error("one-shot trigger did not start a pass");
	a_standby_hold: assert property ((st_q == SQ_IDLE) && standby_i && !trigger_i |=> !busy_o) // RL5
		else $error("pass started in standby without trigger");
	a_active_run: assert property ((st_q == SQ_IDLE) && !standby_i && ready_i && first_w[2] |=> busy_o) // RL14
		else $error("active mode did not convert");
	a_skip_disabled: assert property ($rose(busy_o) |-> en_past_q[chan_o]) // RL15
		else $error("pass started on a disabled channel");
	a_pass_end: assert property ((st_q == SQ_CONV) && cnt_done_w && !next_w[2] && standby_i |=> !busy_o) // RL16
		else $error("busy stayed set after one-shot pass");

endmodule : tfs_conv_seq

// ### rtl/tfs_pkg.sv
// Constants shared by the thermal filter and status register group
package tfs_pkg;

	// ==================================================
	// Command byte offsets
	localparam logic [7:0] OFF_COMMON_STATUS = 8'h02;
	localparam logic [7:0] OFF_CONFIG        = 8'h03;
	localparam logic [7:0] OFF_CONV_ENABLE   = 8'h05;
	localparam logic [7:0] OFF_FILTER_SEL    = 8'h06;
	localparam logic [7:0] OFF_DIODE_FAULT   = 8'h07;
	localparam logic [7:0] OFF_ONE_SHOT      = 8'h0F;

	// ==================================================
	// Reset values
	localparam logic [3:0] RST_FILTER_SEL = 4'hF;
	localparam logic       RST_STANDBY    = 1'b0;
	localparam logic [2:0] RST_CONV_EN    = 3'h7;

	// ==================================================
	// Field positions
	localparam int CFG_STANDBY_BIT = 6;
	localparam int FILT_B_MSB      = 3;
	localparam int FILT_B_LSB      = 2;
	localparam int FILT_A_MSB      = 1;
	localparam int FILT_A_LSB      = 0;
	localparam int CS_BUSY_BIT     = 7;
	localparam int CS_INIT_BIT     = 6;
	localparam int DF_A_SHORT_BIT  = 0;

	// ==================================================
	// Filter codes
	localparam logic [1:0] FILT_OFF   = 2'h0;
	localparam logic [1:0] FILT_BASIC = 2'h1;
	localparam logic [1:0] FILT_RSVD  = 2'h2;
	localparam logic [1:0] FILT_ENH   = 2'h3;

	// ==================================================
	// Forced readings under a diode fault
	localparam logic [7:0] TEMP_FAULT_U = 8'h00;
	localparam logic [7:0] TEMP_FAULT_S = 8'h80;

	// ==================================================
	// Timing
	localparam int CLK_FREQ_HZ  = 100_000_000;
	localparam int INIT_TIME_MS = 30;
	localparam int INIT_CYCLES  = INIT_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int INIT_CNT_W   = 22;
	localparam int CONV_CYCLES  = 1000;
	localparam int CONV_CNT_W   = 16;

	// ==================================================
	// Serial link
	localparam logic [6:0] SMB_ADDR_DEF = 7'h2A;
	localparam logic [3:0] BYTE_BITS    = 4'h8;

endpackage : tfs_pkg

// ### rtl/tfs_regs.sv
// Filter, trigger and status register group behind the serial command link
`timescale 1ns/1ps

// Functional notes
// RL1: Bits 3:2 choose second remote filter
// RL2: Bits 1:0 choose first remote filter
// RL3: Codes 00 off, 01 basic, 11 enhanced
// RL4: Host never writes reserved code 10
// RL5: Trigger write starts one pass in standby
// RL6: Trigger is write-only, data discarded
// RL7: Status bit 7 shows conversion busy
// RL8: Status bit 6 shows 30 ms init
// RL9: Status bits 3:0 OR status groups
// RL10: Fault bits 3/2: second remote open/short
// RL11: Fault bits 1/0 first remote; 7:4 zero
// RL12: Short: D+ low; open: D+ high/floating
// RL13: Faulted channel reads 0 / -128
// RL14: Standby halts periodic, clearing resumes converting
// RL15: Disabled channels are skipped in passes
// RL16: One-shot pass ends, busy clears, standby stays
module tfs_regs #(
	parameter logic [6:0] SMB_ADDR      = tfs_pkg::SMB_ADDR_DEF,
	parameter int         INIT_CYCLES_P = tfs_pkg::INIT_CYCLES,
	parameter int         CONV_CYCLES_P = tfs_pkg::CONV_CYCLES
) (
	input  wire logic       SYS_CLK_I,
	input  wire logic       RST_N_I,
	input  wire logic       SMB_SCL_I,
	input  wire logic       SMB_SDA_I,
	output logic            SMB_SDA_O,
	output logic            SMB_SDA_OE_N_O,
	input  wire logic       REMOTE_A_DP_LOW_I,
	input  wire logic       REMOTE_A_DP_HIGH_I,
	input  wire logic       REMOTE_B_DP_LOW_I,
	input  wire logic       REMOTE_B_DP_HIGH_I,
	input  wire logic [7:0] GROUP_B_STATUS_I,
	input  wire logic [7:0] GROUP_C_STATUS_I,
	input  wire logic [7:0] GROUP_D_STATUS_I,
	input  wire logic [7:0] REMOTE_A_RAW_U_I,
	input  wire logic [7:0] REMOTE_A_RAW_S_I,
	input  wire logic [7:0] REMOTE_B_RAW_U_I,
	input  wire logic [7:0] REMOTE_B_RAW_S_I,
	output logic      [7:0] REMOTE_A_TEMP_U_O,
	output logic      [7:0] REMOTE_A_TEMP_S_O,
	output logic      [7:0] REMOTE_B_TEMP_U_O,
	output logic      [7:0] REMOTE_B_TEMP_S_O,
	output logic      [1:0] REMOTE_A_FILTER_SEL_O,
	output logic      [1:0] REMOTE_B_FILTER_SEL_O,
	output logic            CONV_BUSY_O,
	output logic      [1:0] CONV_CHAN_O,
	output logic            INIT_PENDING_O
);
	import tfs_pkg::*;

	typedef enum logic [2:0] {SM_IDLE, SM_RX, SM_ACK, SM_TX, SM_RACK} tfs_smb_state_t;
	typedef enum logic [1:0] {BK_ADDR, BK_CMD, BK_DATA} tfs_byte_kind_t;

	localparam logic [INIT_CNT_W-1:0] INIT_LAST = INIT_CNT_W'(INIT_CYCLES_P - 1);

	logic [5:0]            sync1_q, sync2_q;
	logic                  scl_d1_q, sda_d1_q;
	logic                  scl_w, sda_w, scl_rise_w, scl_fall_w, start_w, stop_w;
	tfs_smb_state_t        st_q, st_d;
	tfs_byte_kind_t        kind_q, kind_d;
	logic [3:0]            cnt_q, cnt_d;
	logic [7:0]            sh_q, sh_d;
	logic                  rw_q, rw_d;
	logic                  mack_q, mack_d;
	logic [7:0]            cmd_q, cmd_d;
	logic                  oe_n_q, oe_n_d;
	logic                  wr_stb_q, wr_stb_d;
	logic [7:0]            wr_data_q, wr_data_d;
	logic                  sda_out_q;
	logic [3:0]            filter_q;
	logic                  standby_q;
	logic [2:0]            conv_en_q;
	logic                  init_pending_q;
	logic [INIT_CNT_W-1:0] init_cnt_q;
	logic [3:0]            fault_q;
	logic [7:0]            temp_u_q [2];
	logic [7:0]            temp_s_q [2];
	logic [7:0]            raw_u_w [2];
	logic [7:0]            raw_s_w [2];
	logic                  wr_filter_w, wr_config_w, wr_conv_en_w, trig_w;
	logic                  conv_busy_w;
	logic [7:0]            diode_fault_w, cs_w, rd_data_w;
	logic                  group_a_any_set, group_b_any_set, group_c_any_set, group_d_any_set;

	// ==================================================
	// Pin synchronisers and link edges
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			sync1_q  <= 6'h30;
			sync2_q  <= 6'h30;
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
		end else begin
			sync1_q  <= {SMB_SCL_I, SMB_SDA_I, REMOTE_B_DP_HIGH_I, REMOTE_B_DP_LOW_I,
				REMOTE_A_DP_HIGH_I, REMOTE_A_DP_LOW_I};
			sync2_q  <= sync1_q;
			scl_d1_q <= sync2_q[5];
			sda_d1_q <= sync2_q[4];
		end
	end

	assign scl_w      = sync2_q[5];
	assign sda_w      = sync2_q[4];
	assign scl_rise_w = scl_w & ~scl_d1_q;
	assign scl_fall_w = ~scl_w & scl_d1_q;
	assign start_w    = scl_w & scl_d1_q & sda_d1_q & ~sda_w;
	assign stop_w     = scl_w & scl_d1_q & ~sda_d1_q & sda_w;

	// ==================================================
	// Serial slave
	always_comb begin
		st_d      = st_q;
		kind_d    = kind_q;
		cnt_d     = cnt_q;
		sh_d      = sh_q;
		rw_d      = rw_q;
		mack_d    = mack_q;
		cmd_d     = cmd_q;
		oe_n_d    = oe_n_q;
		wr_stb_d  = 1'b0;
		wr_data_d = wr_data_q;
		if (stop_w) begin
			st_d   = SM_IDLE;
			oe_n_d = 1'b1;
		end else if (start_w) begin
			st_d   = SM_RX;
			kind_d = BK_ADDR;
			cnt_d  = 4'h0;
			oe_n_d = 1'b1;
		end else begin
			unique case (st_q)
				SM_IDLE: begin
				end
				SM_RX: begin
					if (scl_rise_w && cnt_q != BYTE_BITS) begin
						sh_d  = {sh_q[6:0], sda_w};
						cnt_d = 4'(cnt_q + 4'h1);
					end else if (scl_fall_w && cnt_q == BYTE_BITS) begin
						if (kind_q == BK_ADDR && sh_q[7:1] != SMB_ADDR) begin
							st_d = SM_IDLE;
						end else begin
							st_d   = SM_ACK;
							oe_n_d = 1'b0;
						end
						if (kind_q == BK_ADDR) begin
							rw_d = sh_q[0];
						end
						if (kind_q == BK_CMD) begin
							cmd_d = sh_q;
						end
						if (kind_q == BK_DATA) begin
							wr_stb_d  = 1'b1;
							wr_data_d = sh_q;
						end
					end
				end
				SM_ACK: begin
					if (scl_fall_w) begin
						cnt_d = 4'h0;
						if (kind_q == BK_ADDR && rw_q) begin
							st_d   = SM_TX;
							sh_d   = rd_data_w;
							oe_n_d = rd_data_w[7];
						end else begin
							st_d   = SM_RX;
							oe_n_d = 1'b1;
							if (kind_q == BK_ADDR) begin
								kind_d = BK_CMD;
							end else begin
								kind_d = BK_DATA;
							end
						end
					end
				end
				SM_TX: begin
					if (scl_fall_w) begin
						if (cnt_q == 4'(BYTE_BITS - 4'h1)) begin
							st_d   = SM_RACK;
							oe_n_d = 1'b1;
						end else begin
							cnt_d  = 4'(cnt_q + 4'h1);
							sh_d   = {sh_q[6:0], 1'b0};
							oe_n_d = sh_q[6];
						end
					end
				end
				SM_RACK: begin
					if (scl_rise_w) begin
						mack_d = ~sda_w;
					end else if (scl_fall_w) begin
						if (mack_q) begin
							st_d   = SM_TX;
							cnt_d  = 4'h0;
							sh_d   = rd_data_w;
							oe_n_d = rd_data_w[7];
						end else begin
							st_d = SM_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			st_q      <= SM_IDLE;
			kind_q    <= BK_ADDR;
			cnt_q     <= 4'h0;
			sh_q      <= 8'h00;
			rw_q      <= 1'b0;
			mack_q    <= 1'b0;
			cmd_q     <= 8'h00;
			oe_n_q    <= 1'b1;
			wr_stb_q  <= 1'b0;
			wr_data_q <= 8'h00;
			sda_out_q <= 1'b0;
		end else begin
			st_q      <= st_d;
			kind_q    <= kind_d;
			cnt_q     <= cnt_d;
			sh_q      <= sh_d;
			rw_q      <= rw_d;
			mack_q    <= mack_d;
			cmd_q     <= cmd_d;
			oe_n_q    <= oe_n_d;
			wr_stb_q  <= wr_stb_d;
			wr_data_q <= wr_data_d;
			sda_out_q <= 1'b0;
		end
	end

	assign SMB_SDA_O      = sda_out_q;
	assign SMB_SDA_OE_N_O = oe_n_q;

	// ==================================================
	// Register writes
	assign wr_filter_w  = wr_stb_q && (cmd_q == OFF_FILTER_SEL);
	assign wr_config_w  = wr_stb_q && (cmd_q == OFF_CONFIG);
	assign wr_conv_en_w = wr_stb_q && (cmd_q == OFF_CONV_ENABLE);
	assign trig_w       = wr_stb_q && (cmd_q == OFF_ONE_SHOT); // RL5 RL6

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			filter_q  <= RST_FILTER_SEL;
			standby_q <= RST_STANDBY;
			conv_en_q <= RST_CONV_EN;
		end else begin
			if (wr_filter_w) begin
				filter_q <= wr_data_q[3:0]; // RL1 RL2 RL3 RL4
			end
			if (wr_config_w) begin
				standby_q <= wr_data_q[CFG_STANDBY_BIT]; // RL14
			end
			if (wr_conv_en_w) begin
				conv_en_q <= wr_data_q[2:0]; // RL15
			end
		end
	end

	assign REMOTE_B_FILTER_SEL_O = filter_q[FILT_B_MSB:FILT_B_LSB]; // RL1
	assign REMOTE_A_FILTER_SEL_O = filter_q[FILT_A_MSB:FILT_A_LSB]; // RL2

	// ==================================================
	// Power-up initialisation
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			init_pending_q <= 1'b1;
			init_cnt_q     <= '0;
		end else if (init_pending_q) begin
			if (init_cnt_q == INIT_LAST) begin
				init_pending_q <= 1'b0; // RL8
			end else begin
				init_cnt_q <= INIT_CNT_W'(init_cnt_q + 1'b1);
			end
		end
	end

	assign INIT_PENDING_O = init_pending_q;

	// ==================================================
	// Diode faults and forced readings
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			fault_q <= 4'h0;
		end else begin
			fault_q <= sync2_q[3:0]; // RL10 RL11 RL12
		end
	end

	assign diode_fault_w = {4'h0, fault_q}; // RL11
	assign raw_u_w[0]    = REMOTE_A_RAW_U_I;
	assign raw_u_w[1]    = REMOTE_B_RAW_U_I;
	assign raw_s_w[0]    = REMOTE_A_RAW_S_I;
	assign raw_s_w[1]    = REMOTE_B_RAW_S_I;

	for (genvar g = 0; g < 2; g++) begin : g_remote
		always_ff @(posedge SYS_CLK_I) begin
			if (!RST_N_I) begin
				temp_u_q[g] <= TEMP_FAULT_U;
				temp_s_q[g] <= TEMP_FAULT_S;
			end else begin
				temp_u_q[g] <= (|fault_q[2*g+1 -: 2]) ? TEMP_FAULT_U : raw_u_w[g]; // RL13
				temp_s_q[g] <= (|fault_q[2*g+1 -: 2]) ? TEMP_FAULT_S : raw_s_w[g]; // RL13
			end
		end
	end

	assign REMOTE_A_TEMP_U_O = temp_u_q[0];
	assign REMOTE_A_TEMP_S_O = temp_s_q[0];
	assign REMOTE_B_TEMP_U_O = temp_u_q[1];
	assign REMOTE_B_TEMP_S_O = temp_s_q[1];

	// ==================================================
	// Conversion sequencer
	tfs_conv_seq #(
		.CONV_CYCLES_P(CONV_CYCLES_P)
	) u_seq (
		.clk_i    (SYS_CLK_I),
		.rst_n_i  (RST_N_I),
		.ready_i  (~init_pending_q),
		.standby_i(standby_q),
		.trigger_i(trig_w),
		.chan_en_i(conv_en_q),
		.busy_o   (conv_busy_w),
		.chan_o   (CONV_CHAN_O)
	);

	assign CONV_BUSY_O = conv_busy_w;

	// ==================================================
	// Read data
	assign group_a_any_set = |diode_fault_w; // RL9
	assign group_b_any_set = |GROUP_B_STATUS_I;
	assign group_c_any_set = |GROUP_C_STATUS_I;
	assign group_d_any_set = |GROUP_D_STATUS_I;
	assign cs_w = {conv_busy_w, init_pending_q, 2'h0, group_d_any_set, group_c_any_set,
		group_b_any_set, group_a_any_set}; // RL7 RL8 RL9
	assign rd_data_w = (cmd_q == OFF_COMMON_STATUS) ? cs_w :
		(cmd_q == OFF_CONFIG)      ? {1'b0, standby_q, 6'h00} :
		(cmd_q == OFF_CONV_ENABLE) ? {5'h00, conv_en_q} :
		(cmd_q == OFF_FILTER_SEL)  ? {4'h0, filter_q} :
		(cmd_q == OFF_DIODE_FAULT) ? diode_fault_w : 8'h00; // RL6

	// ==================================================
	// Checks
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);

	sequence s_filter_write;
		wr_stb_q && (cmd_q == OFF_FILTER_SEL);
	endsequence
	sequence s_trig_write;
		wr_stb_q && (cmd_q == OFF_ONE_SHOT);
	endsequence

	a_filter_b_load: assert property (s_filter_write |=> REMOTE_B_FILTER_SEL_O == $past(wr_data_q[3:2])) // RL1
		else $error("second remote filter not loaded");
	a_filter_a_load: assert property (s_filter_write |=> REMOTE_A_FILTER_SEL_O == $past(wr_data_q[1:0])) // RL2
		else $error("first remote filter not loaded");
	a_filter_hold: assert property (!(wr_stb_q && (cmd_q == OFF_FILTER_SEL)) |=> $stable(filter_q)) // RL3
		else $error("filter code changed without write");
	a_trig_nostore: assert property (s_trig_write |=> $stable(filter_q) && $stable(standby_q) && $stable(conv_en_q)) // RL6
		else $error("trigger write altered stored state");
	a_busy_bit: assert property ((cmd_q == OFF_COMMON_STATUS) |-> rd_data_w[CS_BUSY_BIT] == conv_busy_w) // RL7
		else $error("busy bit mismatch");
	a_init_release: assert property ($fell(init_pending_q) |-> $past(init_cnt_q) == INIT_LAST) // RL8
		else $error("init ended at wrong count");
	a_init_flag: assert property ((cmd_q == OFF_COMMON_STATUS) |-> rd_data_w[CS_INIT_BIT] == init_pending_q) // RL8
		else $error("not-ready bit mismatch");
	a_group_flags: assert property (cs_w[3:0] == {|GROUP_D_STATUS_I, |GROUP_C_STATUS_I,
		|GROUP_B_STATUS_I, |fault_q}) // RL9
		else $error("summary flags wrong");
	a_fault_map: assert property (1'b1 |=> diode_fault_w == {4'h0, $past(sync2_q[3:0])}) // RL10
		else $error("fault bits misplaced");
	a_fault_upper: assert property (diode_fault_w[7:4] == 4'h0) // RL11
		else $error("fault upper bits set");
	a_short_cause: assert property (diode_fault_w[DF_A_SHORT_BIT] |-> $past(sync2_q[0])) // RL12
		else $error("short fault without low diode input");
	a_fault_temp: assert property ((|fault_q[1:0]) |=> REMOTE_A_TEMP_U_O == TEMP_FAULT_U
		&& REMOTE_A_TEMP_S_O == TEMP_FAULT_S) // RL13
		else $error("faulted reading not forced");
	a_standby_load: assert property (wr_config_w |=> standby_q == $past(wr_data_q[CFG_STANDBY_BIT])) // RL14
		else $error("standby bit not loaded");

endmodule : tfs_regs

// ### sim/test_thermal_filter_status_regs.sv
// Self-checking bench for the filter, trigger and status registers
`timescale 1ns/1ps
module test_thermal_filter_status_regs;
	import tfs_pkg::*;
	localparam int CONV = 20;
	localparam int INIT = 2000;
	logic       sys_clk     = 1'b0;
	logic       rst_n       = 1'b0;
	logic       scl;
	logic       sda_host;
	wire        sda_wire;
	logic       sda_drv;
	logic       sda_oe_n;
	logic [3:0] pins        = 4'h0;
	logic [7:0] grp [3]     = '{default: 8'h00};
	logic [7:0] tau, tas, tbu, tbs;
	logic [1:0] fla, flb, chan;
	logic       busy, initp;
	logic [3:0] chan_seen   = 4'h0;
	int         busy_cnt    = 0;
	int         cyc         = 0;
	int         rel         = 0;
	int         miscompares = 0;
	int         check_count = 0;

	always #5 sys_clk = ~sys_clk;
	assign sda_wire = sda_host & (sda_oe_n | sda_drv);

	tfs_smb_host host (.scl_o(scl), .sda_o(sda_host), .sda_i(sda_wire));

	tfs_regs #(.INIT_CYCLES_P(INIT), .CONV_CYCLES_P(CONV)) uut (
		.SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .SMB_SCL_I(scl), .SMB_SDA_I(sda_wire),
		.SMB_SDA_O(sda_drv), .SMB_SDA_OE_N_O(sda_oe_n),
		.REMOTE_A_DP_LOW_I(pins[0]), .REMOTE_A_DP_HIGH_I(pins[1]),
		.REMOTE_B_DP_LOW_I(pins[2]), .REMOTE_B_DP_HIGH_I(pins[3]),
		.GROUP_B_STATUS_I(grp[0]), .GROUP_C_STATUS_I(grp[1]), .GROUP_D_STATUS_I(grp[2]),
		.REMOTE_A_RAW_U_I(8'h55), .REMOTE_A_RAW_S_I(8'h2A), .REMOTE_B_RAW_U_I(8'h66), .REMOTE_B_RAW_S_I(8'h33),
		.REMOTE_A_TEMP_U_O(tau), .REMOTE_A_TEMP_S_O(tas), .REMOTE_B_TEMP_U_O(tbu), .REMOTE_B_TEMP_S_O(tbs),
		.REMOTE_A_FILTER_SEL_O(fla), .REMOTE_B_FILTER_SEL_O(flb),
		.CONV_BUSY_O(busy), .CONV_CHAN_O(chan), .INIT_PENDING_O(initp)
	);

	// ==================================================
	// Busy monitor and timeout
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (busy === 1'b1) begin
			busy_cnt <= busy_cnt + 1;
			chan_seen[chan] <= 1'b1;
		end
		if (cyc == 60000) begin
			miscompares++;
			give_verdict();
		end
	end

	// ==================================================
	// Shared tasks
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic chk_reg(input logic [7:0] cmd, input logic [7:0] exp);
		logic [7:0] d;
		host.rd_reg(cmd, d);
		check($sformatf("reg %h", cmd), d, exp);
	endtask : chk_reg

	// ==================================================
	// Scenarios
	task automatic test_reset();
		check("filter_a", {6'h0, fla}, 8'h03);
		check("filter_b", {6'h0, flb}, 8'h03);
		chk_reg(OFF_FILTER_SEL, 8'h0F);
		chk_reg(OFF_COMMON_STATUS, 8'h40);
		for (int n = 0; n < 3 * INIT && initp !== 1'b0; n++) begin
			@(posedge sys_clk);
		end
		check("init_len", 8'((cyc - rel) >= INIT - 2 && (cyc - rel) <= INIT + 2), 8'h01);
		chk_reg(OFF_COMMON_STATUS, 8'h80);
		$display("test_reset done");
	endtask : test_reset
	task automatic test_oneshot();
		int n;
		host.wr_reg(OFF_CONFIG, 8'h40);
		host.wr_reg(OFF_CONV_ENABLE, 8'h06);
		repeat (CONV * 5) @(posedge sys_clk);
		check("standby_idle", {7'h0, busy}, 8'h00);
		busy_cnt = 0;
		chan_seen = 4'h0;
		host.wr_reg(OFF_ONE_SHOT, 8'hA5);
		repeat (CONV * 6) @(posedge sys_clk);
		check("pass_len", 8'(busy_cnt >= 2 * CONV && busy_cnt <= 2 * CONV + 2), 8'h01);
		check("chan_seen", {4'h0, chan_seen}, 8'h06);
		n = busy_cnt;
		chk_reg(OFF_ONE_SHOT, 8'h00);
		chk_reg(OFF_CONFIG, 8'h40);
		check("no_rerun", 8'(busy_cnt), 8'(n));
		$display("test_oneshot done");
	endtask : test_oneshot
	task automatic test_status();
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk);
			grp[i] <= 8'h01 << (3 * i);
			chk_reg(OFF_COMMON_STATUS, 8'h02 << i);
			@(posedge sys_clk);
			grp[i] <= 8'h00;
		end
		chk_reg(OFF_COMMON_STATUS, 8'h00);
		$display("test_status done");
	endtask : test_status
	task automatic test_fault();
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			pins <= 4'h1 << i;
			chk_reg(OFF_DIODE_FAULT, 8'h01 << i);
			chk_reg(OFF_COMMON_STATUS, 8'h01);
			check("temp_a_u", tau, i < 2 ? TEMP_FAULT_U : 8'h55);
			check("temp_a_s", tas, i < 2 ? TEMP_FAULT_S : 8'h2A);
			check("temp_b_u", tbu, i < 2 ? 8'h66 : TEMP_FAULT_U);
			check("temp_b_s", tbs, i < 2 ? 8'h33 : TEMP_FAULT_S);
		end
		@(posedge sys_clk);
		pins <= 4'h0;
		chk_reg(OFF_DIODE_FAULT, 8'h00);
		check("temp_b_s", tbs, 8'h33);
		$display("test_fault done");
	endtask : test_fault
	task automatic test_filter();
		logic [1:0] code [3] = '{FILT_OFF, FILT_BASIC, FILT_ENH};
		logic [1:0] a, b;
		for (int i = 0; i < 3; i++) begin
			b = code[i];
			a = code[(i + 1) % 3];
			host.wr_reg(OFF_FILTER_SEL, {4'hF, b, a});
			check("filter_a", {6'h0, fla}, {6'h0, a});
			check("filter_b", {6'h0, flb}, {6'h0, b});
			chk_reg(OFF_FILTER_SEL, {4'h0, b, a});
		end
		$display("test_filter done");
	endtask : test_filter
	task automatic test_active();
		host.wr_reg(OFF_CONFIG, 8'h00);
		repeat (10) @(posedge sys_clk);
		check("resume", {7'h0, busy}, 8'h01);
		chk_reg(OFF_COMMON_STATUS, 8'h80);
		check("host_nack", 8'(host.nack_cnt), 8'h00);
		$display("test_active done");
	endtask : test_active

	// ==================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		rel = cyc;
		repeat (3) @(posedge sys_clk);
		test_reset();
		test_oneshot();
		test_status();
		test_fault();
		test_filter();
		test_active();
		give_verdict();
	end
endmodule : test_thermal_filter_status_regs

// ### sim/tfs_smb_host.sv
// Serial command host model for the register link
`timescale 1ns/1ps
module tfs_smb_host #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	output logic      scl_o,
	output logic      sda_o,
	input  wire logic sda_i
);
	localparam realtime Q = 31.25;
	int nack_cnt = 0;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// ==================================================
	// Bit level
	task automatic bit_x(input logic b, output logic r);
		#Q sda_o <= b;
		#Q scl_o <= 1'b1;
		#Q r = sda_i;
		#Q scl_o <= 1'b0;
	endtask : bit_x
	task automatic byte_x(input logic [7:0] d, input logic ack_in, input logic snd, output logic [7:0] r);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r[i]);
		end
		bit_x(ack_in, a);
		if (snd && a !== 1'b0)
			nack_cnt++;
	endtask : byte_x
	task automatic start_c();
		sda_o <= 1'b1;
		#Q scl_o <= 1'b1;
		#Q sda_o <= 1'b0;
		#Q scl_o <= 1'b0;
	endtask : start_c
	task automatic stop_c();
		#Q sda_o <= 1'b0;
		#Q scl_o <= 1'b1;
		#Q sda_o <= 1'b1;
		#Q;
	endtask : stop_c
	// ==================================================
	// Register access
	task automatic wr_reg(input logic [7:0] cmd, input logic [7:0] data);
		logic [7:0] r;
		start_c();
		byte_x({ADDR, 1'b0}, 1'b1, 1'b1, r);
		byte_x(cmd, 1'b1, 1'b1, r);
		byte_x(data, 1'b1, 1'b1, r);
		stop_c();
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] cmd, output logic [7:0] d);
		logic [7:0] r;
		start_c();
		byte_x({ADDR, 1'b0}, 1'b1, 1'b1, r);
		byte_x(cmd, 1'b1, 1'b1, r);
		start_c();
		byte_x({ADDR, 1'b1}, 1'b1, 1'b1, r);
		byte_x(8'hFF, 1'b1, 1'b0, d);
		stop_c();
	endtask : rd_reg
endmodule : tfs_smb_host
